// *** hdl/output_fault_diag_sequencer.v ***
// Speaker output fault diagnostic sequencer with APB register access
//
// Contract
// RQ1 - Host requests turn-on diagnostic at standby exit
// RQ2 - Turn-on classifies ground, supply, across, open
// RQ3 - Hold turn-on result; new pulse after read
// RQ4 - Combined command: pulse first, stage off
// RQ5 - Start permanent diagnostics; keep result until short
// RQ6 - Latch status at plateau end, 100 ms
// RQ7 - Line-driver thresholds only at 16 dB plus option
// RQ8 - Permanent detects shorts and output offset
// RQ9 - Restart mode: only faulted channel shuts down
// RQ10 - Restart mode rechecks every 1 ms
// RQ11 - Diagnostic mode by command, self-activates on overload
// RQ12 - Recheck at 1 ms; clear returns channel active
// RQ13 - Persistent overload starts 100 ms cycle
// RQ14 - After cycle: restart mode, store fault data
// RQ15 - Next cycle only after host read
// RQ16 - Host polls status, over half second
// RQ17 - Host sends unmute before raising standby pin
// RQ18 - Host withholds mute before lowering standby pin
// RQ19 - Select bit picks threshold pair; legacy low only
// RQ20 - Every read rearms all diagnostic cycles; code rearms only on turn-on and permanent fault reads
// RQ21 - Latched per-channel fault code stays readable
`include "diag_seq_map.vh"

module output_fault_diag_sequencer #(
  parameter CHANNELS = 4,
  parameter CHECK_CYCLES = (`CHECK_US * `CLK_MHZ),
  parameter CYCLE_CYCLES = (`CYCLE_MS * 1000 * `CLK_MHZ)
) (
  input wire clock_i,
  input wire rstn_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [CHANNELS-1:0] overload_i,        // Protection trip per channel
  input wire [CHANNELS-1:0] below_gnd_i,       // Output below ground-short level
  input wire [CHANNELS-1:0] above_vs_i,        // Output above supply-short level
  input wire [CHANNELS-1:0] load_short_i,      // Load below short threshold
  input wire [CHANNELS-1:0] load_open_i,       // Load above open threshold
  input wire [CHANNELS-1:0] offset_i,          // Output offset beyond limit
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  output reg stage_on_o,                       // Power stage biased
  output reg pulse_o,                          // Diagnostic current pulse active
  output reg line_thresh_o,                    // Line-driver load thresholds in use
  output reg high_cur_thresh_o,                // High open-load current pair in use
  output reg [CHANNELS-1:0] chan_on_o          // Per-channel enable
);

  // Turn-on sequencer states
  localparam T_IDLE = 2'd0;
  localparam T_PULSE = 2'd1;
  localparam T_DONE = 2'd2;

  //////////////////////////////////////////////////////////////////////
  // Storage and internal state
  reg [`CTRL_WIDTH-1:0] ctrl;          // Software control bits
  reg gain_low;                        // 16 dB gain selected
  reg [1:0] tstate;                    // Turn-on sequencer state
  reg [31:0] ttimer;                   // Pulse plateau timer
  reg [4*CHANNELS-1:0] turnon_res;     // Latched turn-on codes
  reg turnon_valid;                    // A turn-on result is held
  reg turnon_read;                     // Host has read the result
  reg [CHANNELS-1:0] offset_flag;      // Offset persisted since last read
  reg perm_run;                        // Permanent diagnostics running
  reg rearm;                           // One-cycle pulse after a fault read
  reg [3:0] turnon_res_lane [0:CHANNELS-1];   // Turn-on code storage, one word per channel
  // Per-channel engine results and bus strobes
  wire [CHANNELS-1:0] chan_on;
  wire [4*CHANNELS-1:0] perm_fault;
  wire [CHANNELS-1:0] short_seen;
  wire wr_acc;
  wire rd_acc;
  wire next_line;
  wire [CHANNELS-1:0] chan_run_on;

  // Access-phase strobes; a transfer only commits while pready is high
  assign wr_acc = psel_i && penable_i && pwrite_i;
  assign rd_acc = psel_i && penable_i && !pwrite_i;

  // Line-driver thresholds need both the low gain and the option bit [RQ7]
  assign next_line = gain_low && ctrl[`CTRL_LINE_DIAG];                 // [RQ7]

  //////////////////////////////////////////////////////////////////////
  // Classify one channel from its comparators
  function [3:0] classify;
    input gnd;
    input vs;
    input sh;
    input op;
    begin
      classify = `FAULT_NONE;
      // Ground and supply shorts may both be flagged at once
      if (gnd)
        classify = classify | `FAULT_GND;
      if (vs)
        classify = classify | `FAULT_VS;
      if (sh)
        classify = classify | `FAULT_ACROSS;
      // An open load is only reported when no short hides it
      if (op && !gnd && !vs && !sh)
        classify = classify | `FAULT_OPEN;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, unmapped addresses answer with error
  always @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      ctrl <= `CTRL_RESET;
      gain_low <= 1'b0;
      prdata_o <= 32'h00000000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      rearm <= 1'b0;
    end
    else
    begin
      // Ready answers the cycle after setup, so every access lasts one cycle
      pready_o <= psel_i && !penable_i;
      pslverr_o <= 1'b0;
      rearm <= 1'b0;
      if (psel_i && !penable_i)
      begin
        // Decode in the setup cycle so data is ready with pready
        prdata_o <= 32'h00000000;
        case (paddr_i)
          `ADDR_CTRL:
            prdata_o[`CTRL_WIDTH-1:0] <= ctrl;
          `ADDR_GAIN:
            prdata_o[`GAIN_LOW_BIT] <= gain_low;
          `ADDR_TURNON:
            prdata_o[4*CHANNELS-1:0] <= turnon_res;                     // [RQ3]
          `ADDR_PERM:
            prdata_o[4*CHANNELS-1:0] <= perm_fault;                     // [RQ21]
          `ADDR_STATUS:
            prdata_o[2*CHANNELS+2:0] <= {offset_flag, chan_on, perm_run, turnon_valid, pulse_o};
          default:
            pslverr_o <= 1'b1;
        endcase
      end
      if (wr_acc && pready_o)
      begin
        case (paddr_i)
          `ADDR_CTRL:
            ctrl <= pwdata_i[`CTRL_WIDTH-1:0];
          `ADDR_GAIN:
            gain_low <= pwdata_i[`GAIN_LOW_BIT];
          // Read-only and unmapped words ignore writes
          default:
            ctrl <= ctrl;
        endcase
      end
      // Reading the fault bytes rearms every cycle kind [RQ20]
      // Status polling leaves the running cycles alone
      if (rd_acc && pready_o && (paddr_i == `ADDR_TURNON || paddr_i == `ADDR_PERM))
        rearm <= 1'b1;                                                  // [RQ20]
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Turn-on pulse: runs before biasing, result held until host read
  always @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      tstate <= T_IDLE;
      ttimer <= 32'h00000000;
      turnon_valid <= 1'b0;
      turnon_read <= 1'b1;
      perm_run <= 1'b0;
      stage_on_o <= 1'b0;
      pulse_o <= 1'b0;
    end
    else
    begin
      if (rearm)
        turnon_read <= 1'b1;                                            // [RQ3]
      case (tstate)
        T_IDLE:
        begin
          stage_on_o <= 1'b0;
          perm_run <= 1'b0;
          // Stage stays off while the pulse runs [RQ4]
          if (ctrl[`CTRL_STANDBY_MUTE_PIN_OUT] && ctrl[`CTRL_DIAG_EN] && turnon_read)
          begin
            pulse_o <= 1'b1;                                            // [RQ4]
            ttimer <= 32'h00000000;
            tstate <= T_PULSE;
          end
          else if (ctrl[`CTRL_STANDBY_MUTE_PIN_OUT])
            tstate <= T_DONE;
        end
        T_PULSE:
        begin
          // Plateau end: the lane blocks latch the comparators on this edge [RQ6]
          if (ttimer >= CYCLE_CYCLES - 1)
          begin
            pulse_o <= 1'b0;
            turnon_valid <= 1'b1;
            turnon_read <= 1'b0;                                        // [RQ3]
            tstate <= T_DONE;
          end
          else
            ttimer <= ttimer + 32'h00000001;
        end
        T_DONE:
        begin
          // Biased: permanent diagnostics run until standby returns
          stage_on_o <= 1'b1;
          perm_run <= 1'b1;                                             // [RQ5]
          if (!ctrl[`CTRL_STANDBY_MUTE_PIN_OUT])
            tstate <= T_IDLE;
        end
        default:
          tstate <= T_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Result latch at plateau end; a short on an output clears its code
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1)
    begin : lane
      // Offset flag: armed by a fault read, dropped once the offset lapses or a short trips
      always @(posedge clock_i)
      begin
        if (!rstn_i)
          offset_flag[g] <= 1'b0;
        else if (rearm)
          offset_flag[g] <= ctrl[`CTRL_OFFSET_EN] && offset_i[g];
        else if (!offset_i[g] || overload_i[g] || !ctrl[`CTRL_OFFSET_EN])
          offset_flag[g] <= 1'b0;                                       // [RQ8]
      end
      // Single writer for each turn-on code: latch or short-driven drop
      always @(posedge clock_i)
      begin
        if (rstn_i && tstate == T_PULSE && ttimer >= CYCLE_CYCLES - 1)
          turnon_res_lane[g] <= classify(below_gnd_i[g], above_vs_i[g],
                                         load_short_i[g], load_open_i[g]); // [RQ2] [RQ6]
        else if (!rstn_i || short_seen[g])
          turnon_res_lane[g] <= `FAULT_NONE;                            // [RQ5]
      end
      // Open load is no permanent fault, so that comparator is masked here
      diag_channel #(
        .CHECK_CYCLES(CHECK_CYCLES),
        .CYCLE_CYCLES(CYCLE_CYCLES)
      ) u_chan (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .perm_run_i(perm_run),
        .diag_en_i(ctrl[`CTRL_DIAG_EN]),
        .overload_i(overload_i[g]),
        .cmp_code_i(classify(below_gnd_i[g], above_vs_i[g], load_short_i[g], 1'b0)),
        .rearm_i(rearm),
        .chan_on_o(chan_on[g]),
        .fault_o(perm_fault[4*g+3:4*g]),
        .short_seen_o(short_seen[g])
      );
      // Follow the stage's next state so enable and stage rise and fall on one edge
      assign chan_run_on[g] = chan_on[g] && (tstate == T_DONE);
    end
  endgenerate

  // Flatten stored codes for the register view
  integer k;
  always @*
  begin
    turnon_res = {4*CHANNELS{1'b0}};
    for (k = 0; k < CHANNELS; k = k + 1)
      turnon_res[4*k +: 4] = turnon_res_lane[k];
  end

  //////////////////////////////////////////////////////////////////////
  // Registered outputs toward the analog side
  always @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      line_thresh_o <= 1'b0;
      high_cur_thresh_o <= 1'b0;
      chan_on_o <= {CHANNELS{1'b0}};
    end
    else
    begin
      line_thresh_o <= next_line;                                       // [RQ7]
      // Legacy mode forces the low current pair [RQ19]
      high_cur_thresh_o <= !ctrl[`CTRL_CUR_SEL] && !ctrl[`CTRL_LEGACY]; // [RQ19]
      // Stage off forces every channel off, whatever its engine state
      chan_on_o <= chan_run_on;                                         // [RQ9]
    end
  end

endmodule

// *** hdl/diag_seq_map.vh ***
// Constants shared by the output fault diagnostic sequencer and its channel engine
`ifndef DIAG_SEQ_MAP_VH
`define DIAG_SEQ_MAP_VH

// APB byte addresses
`define ADDR_CTRL      12'h000
`define ADDR_GAIN      12'h004
`define ADDR_TURNON    12'h008
`define ADDR_PERM      12'h00c
`define ADDR_STATUS    12'h010

// Control register bit positions
`define CTRL_STANDBY_MUTE_PIN_OUT  0
`define CTRL_DIAG_EN   1
`define CTRL_OFFSET_EN 2
`define CTRL_LEGACY    3
`define CTRL_CUR_SEL   4
`define CTRL_LINE_DIAG 5
`define CTRL_WIDTH     6
`define CTRL_RESET     6'h00

// Gain register: bit 0 set selects the 16 dB setting
`define GAIN_LOW_BIT   0

// Fault codes, four bits per channel
`define FAULT_NONE     4'h0
`define FAULT_GND      4'h1
`define FAULT_VS       4'h2
`define FAULT_ACROSS   4'h4
`define FAULT_OPEN     4'h8
`define FAULT_OFFSET   4'h8

// Timing: interval in microseconds, cycle in milliseconds, clock in MHz
`define CLK_MHZ        100
`define CHECK_US       1000
`define CYCLE_MS       100

`endif

// *** hdl/diag_channel.v ***
// Per-channel restart and diagnostic mode engine for one speaker output
`include "diag_seq_map.vh"

module diag_channel #(
  parameter CHECK_CYCLES = 100000,
  parameter CYCLE_CYCLES = 10000000
) (
  input wire clock_i,
  input wire rstn_i,
  input wire perm_run_i,          // Permanent diagnostics running
  input wire diag_en_i,           // Diagnostic mode enabled by command
  input wire overload_i,          // Short-circuit protection tripped
  input wire [3:0] cmp_code_i,    // Comparator fault classification
  input wire rearm_i,             // Host read: next cycle may start
  output reg chan_on_o,           // Channel enabled
  output reg [3:0] fault_o,       // Latched fault of the last cycle
  output reg short_seen_o         // A short appeared on this output
);

  localparam S_ACTIVE = 3'd0;
  localparam S_RECHECK = 3'd1;
  localparam S_CYCLE = 3'd2;
  localparam S_RESTART = 3'd3;
  localparam S_HOLD = 3'd4;

  reg [2:0] state;          // Engine state
  reg [31:0] timer;         // Shared interval counter
  reg [3:0] worst;          // Fault seen during the cycle
  reg done;                 // Cycle ended, waiting for host read

  //////////////////////////////////////////////////////////////////////
  // Sequencer: one timer serves recheck, cycle and restart sampling
  always @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      state <= S_ACTIVE;
      timer <= 32'h00000000;
      worst <= `FAULT_NONE;
      done <= 1'b0;
      chan_on_o <= 1'b1;
      fault_o <= `FAULT_NONE;
      short_seen_o <= 1'b0;
    end
    else
    begin
      if (rearm_i)
        done <= 1'b0;                                           // [RQ15]
      case (state)
        S_ACTIVE:
        begin
          chan_on_o <= 1'b1;
          timer <= 32'h00000000;
          if (perm_run_i && overload_i)
          begin
            chan_on_o <= 1'b0;                                  // [RQ9]
            short_seen_o <= 1'b1;                               // [RQ5]
            // Diagnostic mode self-activates on a protection trip when enabled and no cycle result awaits a read [RQ11]
            if (diag_en_i && !done)
              state <= S_RECHECK;
            else
              state <= S_RESTART;
          end
        end
        S_RECHECK:
        begin
          // Spike filter: judge the output only after the check interval
          if (timer >= CHECK_CYCLES - 1)
          begin
            timer <= 32'h00000000;
            worst <= `FAULT_NONE;
            if (overload_i)
              state <= S_CYCLE;                                 // [RQ13]
            else
              state <= S_ACTIVE;                                // [RQ12]
          end
          else
            timer <= timer + 32'h00000001;
        end
        S_CYCLE:
        begin
          worst <= worst | (cmp_code_i & ~`FAULT_OPEN);         // [RQ8]
          if (timer >= CYCLE_CYCLES - 1)
          begin
            timer <= 32'h00000000;
            fault_o <= worst | (cmp_code_i & ~`FAULT_OPEN);     // [RQ14] [RQ21]
            done <= 1'b1;
            state <= S_RESTART;                                 // [RQ14]
          end
          else
            timer <= timer + 32'h00000001;
        end
        S_RESTART:
        begin
          // Stays off; sample output once per interval [RQ10]
          if (timer >= CHECK_CYCLES - 1)
          begin
            timer <= 32'h00000000;
            if (!overload_i)
              state <= S_ACTIVE;                                // [RQ10]
          end
          else
            timer <= timer + 32'h00000001;
        end
        default:
          state <= S_ACTIVE;
      endcase
      if (!perm_run_i)
        short_seen_o <= 1'b0;
    end
  end

endmodule

// *** sim/output_fault_diag_sequencer_asserts.sv ***
// Port checks for the output fault diagnostic sequencer
module diag_seq_asserts #(
  parameter CHANNELS = 4
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [CHANNELS-1:0] overload_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic stage_on_o,
  input wire logic pulse_o,
  input wire logic [CHANNELS-1:0] chan_on_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // One clock domain, so one default for all
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);
  ////////////////////////////////////////
  // Setup phase of a bus transfer
  sequence setup_s;
    psel_i && !penable_i;
  endsequence
  // Access phase of a bus transfer
  sequence access_s;
    psel_i && penable_i;
  endsequence
  ////////////////////////////////////////
  ready_after_setup_a: assert property (setup_s |=> pready_o)
    else $error("ready missing after setup");
  ready_in_access_a: assert property (pready_o |-> access_s)
    else $error("ready outside access phase");
  err_with_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  pulse_stage_off_a: assert property (pulse_o |-> !stage_on_o && chan_on_o == 0)
    else $error("stage on during pulse");
  chan_needs_stage_a: assert property (|chan_on_o |-> stage_on_o)
    else $error("channel on with stage off");
  // Protection trip must take the channel down quickly
  overload_shut_a: assert property ($rose(overload_i[1]) && chan_on_o[1] |-> ##[1:4] !chan_on_o[1])
    else $error("overloaded channel kept on");
  restart_clear_a: assert property ($rose(chan_on_o[1]) |-> !$past(overload_i[1]))
    else $error("restart while overloaded");
  stays_off_a: assert property (overload_i[1] && !chan_on_o[1] |=> !chan_on_o[1])
    else $error("channel back during overload");
endmodule

// *** sim/diag_host_model.sv ***
// Host microcontroller model: APB master on the control bus
module diag_host_model (
  input wire logic clock_i,
  input wire logic pready_i,
  input wire logic pslverr_i,
  input wire logic [31:0] prdata_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [11:0] paddr_o,
  output logic [31:0] pwdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] rdata; // Data of the last read
  logic err; // Error flag of the last transfer
  // Bus idle at time zero
  initial
  begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 12'h000;
    pwdata_o = 32'h0;
  end
  ////////////////////////////////////////
  // One transfer; the caller picks when, so polling rate is the host's
  // Turn-on request is just a control write from here
  // Register writes and reads are the only host traffic; no mute write precedes a standby ramp
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel_o <= 1'b1;
    pwrite_o <= wr;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clock_i);
    penable_o <= 1'b1;
    // Hold everything until ready is seen; bench timeout ends a hang
    do
      @(posedge clock_i);
    while (pready_i !== 1'b1);
    rdata = prdata_i;
    err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // Released data bus toggles so stale values cannot look valid
    pwdata_o <= ~d;
  endtask
endmodule

// *** sim/output_fault_diag_sequencer_test.sv ***
// Self-checking bench for the output fault diagnostic sequencer
`include "diag_seq_map.vh"
module output_fault_diag_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CH = 20; // Shortened 1 ms check interval
  localparam int CY = 100; // Shortened diagnostic cycle
  logic clock_i, rstn_i, psel, penable, pwrite, pready, pslverr;
  logic stage_on, pulse, line_th, hi_th;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] ovl, gnd, vs, shrt, opn, ofs, chan_on;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  output_fault_diag_sequencer #(.CHECK_CYCLES(CH), .CYCLE_CYCLES(CY)) dut_u (
    .clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .overload_i(ovl),
    .below_gnd_i(gnd), .above_vs_i(vs), .load_short_i(shrt), .load_open_i(opn),
    .offset_i(ofs), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .stage_on_o(stage_on), .pulse_o(pulse), .line_thresh_o(line_th),
    .high_cur_thresh_o(hi_th), .chan_on_o(chan_on));
  diag_host_model host_u (
    .clock_i(clock_i), .pready_i(pready), .pslverr_i(pslverr), .prdata_i(prdata),
    .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));
  ////////////////////////////////////////
  // Compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Wait a bounded time for a channel pattern, then judge it
  task automatic wait_chan(input logic [3:0] e, input int lim);
    int n;
    n = 0;
    while (chan_on !== e && n < lim)
    begin
      @(posedge clock_i);
      n++;
    end
    chk("chan_on", {28'h0, chan_on}, {28'h0, e});
  endtask
  // Wait a bounded time for the pulse flag to reach a level
  task automatic wait_pulse(input logic e, input int lim);
    int n;
    n = 0;
    while (pulse !== e && n < lim)
    begin
      @(posedge clock_i);
      n++;
    end
  endtask
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////
  // Reset value, refusal, threshold selects
  task automatic t_regs;
    host_u.xfer(1'b0, `ADDR_CTRL, 32'h0);
    chk("ctrl", host_u.rdata, 32'h0);
    host_u.xfer(1'b1, 12'h0fc, 32'hffff_ffff);
    chk("slverr", {31'h0, host_u.err}, 32'h1);
    host_u.xfer(1'b1, `ADDR_GAIN, 32'h1);
    host_u.xfer(1'b1, `ADDR_CTRL, 32'h20);
    host_u.xfer(1'b0, `ADDR_CTRL, 32'h0);
    chk("ctrl rb", host_u.rdata, 32'h20);
    chk("line", {31'h0, line_th}, 32'h1);
    host_u.xfer(1'b1, `ADDR_GAIN, 32'h0);
    host_u.xfer(1'b0, `ADDR_GAIN, 32'h0);
    chk("line off", {31'h0, line_th}, 32'h0);
    // Every combination of legacy and current select
    for (int i = 0; i < 4; i++)
    begin
      host_u.xfer(1'b1, `ADDR_CTRL, {27'h0, i[0], i[1], 3'h0});
      host_u.xfer(1'b0, `ADDR_STATUS, 32'h0);
      chk("hi_cur", {31'h0, hi_th}, {31'h0, i == 0});
    end
  endtask
  // Combined standby exit and diagnostic enable, one fault per channel
  task automatic t_turnon;
    int n;
    @(posedge clock_i);
    gnd <= 4'h1;
    vs <= 4'h2;
    shrt <= 4'h4;
    opn <= 4'h8;
    host_u.xfer(1'b1, `ADDR_CTRL, 32'h3);
    wait_pulse(1'b1, 20);
    chk("pulse", {31'h0, pulse}, 32'h1);
    chk("stage", {31'h0, stage_on}, 32'h0);
    wait_pulse(1'b0, 2 * CY + 40);
    chk("pulse end", {31'h0, pulse}, 32'h0);
    gnd <= 4'h0;
    vs <= 4'h0;
    shrt <= 4'h0;
    opn <= 4'h0;
    wait_chan(4'hf, 40);
    // Standby cycled without a read: no second pulse
    host_u.xfer(1'b1, `ADDR_CTRL, 32'h0);
    host_u.xfer(1'b1, `ADDR_CTRL, 32'h3);
    n = 0;
    repeat (CY)
    begin
      @(posedge clock_i);
      n += pulse;
    end
    chk("repulse", n, 32'h0);
    host_u.xfer(1'b0, `ADDR_TURNON, 32'h0);
    chk("turnon", host_u.rdata, 32'h8421);
    // The read frees the next pulse, whose clean result shows on the second read
    host_u.xfer(1'b1, `ADDR_CTRL, 32'h0);
    host_u.xfer(1'b1, `ADDR_CTRL, 32'h3);
    wait_pulse(1'b1, 20);
    chk("new pulse", {31'h0, pulse}, 32'h1);
    wait_pulse(1'b0, 2 * CY + 40);
    host_u.xfer(1'b0, `ADDR_TURNON, 32'h0);
    chk("turnon again", host_u.rdata, 32'h0);
    wait_chan(4'hf, 40);
  endtask
  // Restart mode: independent channels, rechecked each interval
  task automatic t_restart;
    host_u.xfer(1'b1, `ADDR_CTRL, 32'h1);
    @(posedge clock_i);
    ovl <= 4'h2;
    wait_chan(4'hd, 10);
    repeat (3 * CH) @(posedge clock_i);
    chk("held off", {28'h0, chan_on}, 32'hd);
    ovl <= 4'h0;
    wait_chan(4'hf, CH + 10);
  endtask
  // Diagnostic mode: glitch skipped, persistent fault stored
  task automatic t_diag;
    host_u.xfer(1'b1, `ADDR_CTRL, 32'h3);
    @(posedge clock_i);
    ovl <= 4'h4;
    wait_chan(4'hb, 10);
    ovl <= 4'h0;
    wait_chan(4'hf, CH + 10);
    ovl <= 4'h8;
    gnd <= 4'h8;
    wait_chan(4'h7, 10);
    repeat (CH + CY + 20) @(posedge clock_i);
    host_u.xfer(1'b0, `ADDR_PERM, 32'h0);
    chk("perm", host_u.rdata, 32'h1000);
    chk("faulted", {28'h0, chan_on}, 32'h7);
    ovl <= 4'h0;
    gnd <= 4'h0;
    wait_chan(4'hf, 2 * CH + 10);
  endtask
  ////////////////////////////////////////
  // Offset flag: armed by a fault read, kept only while the offset persists
  task automatic t_offset;
    host_u.xfer(1'b1, `ADDR_CTRL, 32'h5);
    @(posedge clock_i);
    ofs <= 4'h1;
    host_u.xfer(1'b0, `ADDR_PERM, 32'h0);
    host_u.xfer(1'b0, `ADDR_STATUS, 32'h0);
    chk("offset on", {28'h0, host_u.rdata[10:7]}, 32'h1);
    ofs <= 4'h0;
    host_u.xfer(1'b0, `ADDR_STATUS, 32'h0);
    chk("offset off", {28'h0, host_u.rdata[10:7]}, 32'h0);
  endtask
  ////////////////////////////////////////
  // Free-running 100 MHz clock
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // Main sequence
  initial
  begin
    rstn_i = 1'b0;
    ovl = 4'h0;
    gnd = 4'h0;
    vs = 4'h0;
    shrt = 4'h0;
    opn = 4'h0;
    ofs = 4'h0;
    repeat (16) @(posedge clock_i);
    rstn_i <= 1'b1;
    t_regs();
    t_turnon();
    t_restart();
    t_diag();
    t_offset();
    conclude();
  end
  // Hang guard, well above the several hundred cycles needed
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      err_count++;
      conclude();
    end
  end
endmodule
bind output_fault_diag_sequencer diag_seq_asserts #(.CHANNELS(CHANNELS)) chk_u (
  .clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
  .overload_i(overload_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .stage_on_o(stage_on_o), .pulse_o(pulse_o), .chan_on_o(chan_on_o));
